// File: rtl/synth_cfg_regs.svh
// Register offsets, field positions, reset values and frame sizes of the
// synthesizer configuration bank.
// Assumes inclusion by bare name from any file that needs the constants.
`ifndef SYNTH_CFG_REGS_SVH
`define SYNTH_CFG_REGS_SVH

// Byte sub-addresses of the six write-only configuration registers.
`define SUB_OP_MODE       8'h00
`define SUB_B_HIGH        8'h01
`define SUB_A_B_LOW       8'h02
`define SUB_REF_HIGH      8'h03
`define SUB_LOOP          8'h04
`define SUB_VCO_CAL       8'h05
`define CFG_REG_COUNT     6
`define CFG_BYTE_RST      8'h00

// Field positions inside the configuration bytes.
`define MODE_PIN_CTRL_BIT 7
`define MODE_RECAL_BIT    6
`define CAL_TEST_A_BIT    7
`define CAL_GO_BIT        6
`define CAL_TEST_B_BIT    5
`define LOOP_PSC_BIT      0

// Fixed upper nibble of the two-wire slave address.
`define I2C_PREFIX        4'hC

// Three-wire frame: two address bits, then 24 data bits, MSB first.
`define SER_FRAME_BITS    26
`define SER_DATA_BITS     24
`define SER_ADDR_WORD0    2'h0
`define SER_ADDR_WORD1    2'h1
`define SER_CLK_MAX_MHZ   100

// Number of pin inputs that pass the two-stage synchroniser.
`define SYNC_WIDTH        13
// Reset value of the synchroniser: two-wire clock and data lines released high.
`define SYNC_IDLE         13'h1800

`endif

// File: rtl/synth_cfg_pkg.sv
// Types shared by the configuration bank and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package synth_cfg_pkg;

  // Two-wire slave protocol phases.
  typedef enum {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_SUB, ST_SUB_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } i2c_state_e;

  // Oscillator source chosen by the operating mode.
  typedef enum logic [1:0] {SRC_NONE, SRC_VCO_A, SRC_VCO_B, SRC_EXT} vco_src_e;

  // Output division chosen by the operating mode.
  typedef enum logic [1:0] {DIV_NONE, DIV_2, DIV_4, DIV_1} out_div_e;

  // Decoded synthesizer settings handed to the analog core.
  typedef struct packed {
    logic        outStagePinCtrlOn;
    logic        recalAutoOn;
    logic [4:0]  opModeCode;
    logic        powerDown;
    vco_src_e    vcoSrc;
    out_div_e    outDiv;
    logic [11:0] bCount;
    logic [4:0]  aCount;
    logic [9:0]  refDiv;
    logic [1:0]  vcoAmplitude;
    logic [2:0]  pumpCurrentSel;
    logic        modulusChoice;
    logic        testCtlA;
    logic        calGo;
    logic        testCtlB;
    logic [4:0]  calTrim;
  } synth_cfg_s;

endpackage

// File: rtl/synth_config_register_bank.sv
// Configuration and status register bank of a frequency synthesizer, reached
// either over a two-wire slave port or over a write-only three-wire port.
// Assumes the analog core supplies lock, control word and a done pulse on clk.
//
// Operation
// - Six write-only bytes plus one status byte.
// - Mode byte: pin control, auto-restart, mode, B11.
// - Mode code 0 off, 1-9 source and division.
// - B counter and A counter spread over bytes.
// - Reference divider from byte three and two bits.
// - Loop byte holds amplitude and pump current.
// - Loop bit zero picks modulus 16 or 19.
// - Calibration start bit clears itself when done.
// - Status shows identifier and VCO control word.
// - Status bit five shows PLL lock.
// - Read returns status with no sub-address.
// - All six configuration bytes clear to zero at reset.
// - High strap selects three-wire port over two-wire.
// - Three-wire port is write-only, up to 100 MHz.
// - Frame is 26 bits, address then data, MSB first.
// - Serial bits shift in on rising serial clock.
// - Rising load moves shifted word into registers.
// - Word 0 loop and calibration, word 1 mode; others reserved.
// - Slave address is 1100 then three pin bits.
// - Write data bytes go to incrementing sub-addresses.
`timescale 1ns/1ps
`include "synth_cfg_regs.svh"

module synth_config_register_bank
  import synth_cfg_pkg::*;
#(
  parameter logic [1:0] PART_IDENT = 2'h2  // Arbitrary identifier value.
)(
  // System clock and synchronous reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Straps.
  input  wire logic       portSelectStrap,
  input  wire logic [2:0] addrPins,
  // Two-wire slave port; sdaOe high pulls the line low.
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Three-wire write-only port.
  input  wire logic       serClk,
  input  wire logic       serData,
  input  wire logic       serLoad,
  // Analog core status.
  input  wire logic       pllLockedPin,
  input  wire logic [4:0] vcoCtrlWordPin,
  input  wire logic       calDone,
  // Decoded settings.
  output synth_cfg_s      cfg,
  output logic            serialSelected
);

  // Two-stage synchroniser for every asynchronous pin.
  logic [`SYNC_WIDTH-1:0]   syncA_ff;       // First stage, read only by second.
  logic [`SYNC_WIDTH-1:0]   syncB_ff;       // Second stage, safe to use.
  logic                     sclDly_ff;      // Delayed clock line for edges.
  logic                     sdaDly_ff;      // Delayed data line for edges.
  logic                     loadDly_ff;     // Delayed load strobe for edges.
  logic [`SER_FRAME_BITS-1:0] serShift_ff;  // Link-domain shift register.
  logic [5:0][7:0]          cfgRegs_ff;     // The six configuration bytes.
  i2c_state_e               state_ff;       // Two-wire protocol phase.
  logic [3:0]               bitCnt_ff;      // Bits seen in the current byte.
  logic [7:0]               shiftIn_ff;     // Incoming byte.
  logic [7:0]               rdShift_ff;     // Outgoing status byte.
  logic [7:0]               subPtr_ff;      // Current sub-address.
  logic                     rwBit_ff;       // Direction of the transfer.

  // Named views of the synchronised pins.
  logic       sclS, sdaS, loadS, strapS, lockS;
  logic [4:0] vcoWordS;
  logic [2:0] addrS;
  assign {sclS, sdaS, loadS, strapS, lockS, vcoWordS, addrS} = syncB_ff;

  // Edge and bus condition detection on the synchronised lines.
  logic sclRise, sclFall, startCond, stopCond, loadRise;
  assign sclRise   = sclS & ~sclDly_ff;
  assign sclFall   = ~sclS & sclDly_ff;
  assign startCond = sclS & sclDly_ff & ~sdaS & sdaDly_ff;
  assign stopCond  = sclS & sclDly_ff & sdaS & ~sdaDly_ff;
  assign loadRise  = loadS & ~loadDly_ff;

  // Status byte: identifier, lock, internal VCO control word.
  logic [7:0] statusByte;
  assign statusByte = {PART_IDENT, lockS, vcoWordS};

  // Serial word split into address and data.
  logic [1:0]                 serAddr;
  logic [`SER_DATA_BITS-1:0]  serWord;
  assign serAddr = serShift_ff[`SER_FRAME_BITS-1 -: 2];
  assign serWord = serShift_ff[`SER_DATA_BITS-1:0];

  // Write strobe from the two-wire port, one cycle per data byte.
  logic wrStrobe;
  assign wrStrobe = (state_ff == ST_WR) && sclFall && (bitCnt_ff == 4'h8);

  // Open-drain line is only ever pulled low.
  assign sdaOut = 1'b0;

  // Mode code decode into source and division; codes above nine power down.
  function automatic logic [4:0] decodeMode(input logic [4:0] code);
    logic [4:0] res;
    res = {1'b1, SRC_NONE, DIV_NONE};
    unique case (code)
      5'h01: res = {1'b0, SRC_VCO_A, DIV_2};
      5'h02: res = {1'b0, SRC_VCO_B, DIV_2};
      5'h03: res = {1'b0, SRC_EXT,   DIV_2};
      5'h04: res = {1'b0, SRC_VCO_A, DIV_4};
      5'h05: res = {1'b0, SRC_VCO_B, DIV_4};
      5'h06: res = {1'b0, SRC_EXT,   DIV_4};
      5'h07: res = {1'b0, SRC_VCO_A, DIV_1};
      5'h08: res = {1'b0, SRC_VCO_B, DIV_1};
      5'h09: res = {1'b0, SRC_EXT,   DIV_1};
      default: res = {1'b1, SRC_NONE, DIV_NONE};
    endcase
    return res;
  endfunction

  // Assemble the settings from the six bytes; both ports land in these bytes.
  function automatic synth_cfg_s buildCfg(input logic [5:0][7:0] r);
    synth_cfg_s c;
    logic [4:0] md;
    c = '0;
    c.outStagePinCtrlOn = r[0][`MODE_PIN_CTRL_BIT];
    c.recalAutoOn       = r[0][`MODE_RECAL_BIT];
    c.opModeCode        = r[0][5:1];
    md                  = decodeMode(r[0][5:1]);
    c.powerDown         = md[4];
    c.vcoSrc            = vco_src_e'(md[3:2]);
    c.outDiv            = out_div_e'(md[1:0]);
    c.bCount            = {r[0][0], r[1], r[2][7:5]};
    c.aCount            = r[2][4:0];
    c.refDiv            = {r[3], r[4][7:6]};
    c.vcoAmplitude      = r[4][5:4];
    c.pumpCurrentSel    = r[4][3:1];
    c.modulusChoice     = r[4][`LOOP_PSC_BIT];
    c.testCtlA          = r[5][`CAL_TEST_A_BIT];
    c.calGo             = r[5][`CAL_GO_BIT];
    c.testCtlB          = r[5][`CAL_TEST_B_BIT];
    c.calTrim           = r[5][4:0];
    return c;
  endfunction

  // Pin synchroniser; resets to the idle line levels so no false edge follows.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      syncA_ff   <= `SYNC_IDLE;
      syncB_ff   <= `SYNC_IDLE;
      sclDly_ff  <= 1'b1;
      sdaDly_ff  <= 1'b1;
      loadDly_ff <= 1'b0;
    end
    else
    begin
      syncA_ff   <= {scl, sdaIn, serLoad, portSelectStrap, pllLockedPin,
                     vcoCtrlWordPin, addrPins};
      syncB_ff   <= syncA_ff;
      sclDly_ff  <= sclS;
      sdaDly_ff  <= sdaS;
      loadDly_ff <= loadS;
    end
  end

  // Port selection follows the synchronised strap, which is tied on the board.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      serialSelected <= 1'b0;
    else
      serialSelected <= strapS;
  end

  // Link-domain shift register. It holds data only, so it needs no reset;
  // the serial clock stops between frames, which keeps the word still while
  // the load strobe is brought across.
  always_ff @(posedge serClk)
  begin
    serShift_ff <= {serShift_ff[`SER_FRAME_BITS-2:0], serData};
  end

  // Two-wire slave protocol engine; held idle while the serial port is chosen.
  always_ff @(posedge clk)
  begin
    if (sys_rst || serialSelected)
    begin
      state_ff   <= ST_IDLE;
      bitCnt_ff  <= 4'h0;
      shiftIn_ff <= 8'h00;
      rdShift_ff <= 8'hFF;
      subPtr_ff  <= 8'h00;
      rwBit_ff   <= 1'b0;
    end
    else if (startCond)
    begin
      // A start, repeated or not, always restarts address matching.
      state_ff  <= ST_DEV;
      bitCnt_ff <= 4'h0;
    end
    else if (stopCond)
      state_ff <= ST_IDLE;
    else if (sclRise)
    begin
      unique case (state_ff)
        ST_DEV, ST_SUB, ST_WR:
        begin
          shiftIn_ff <= {shiftIn_ff[6:0], sdaS};
          bitCnt_ff  <= bitCnt_ff + 4'h1;
        end
        ST_RD:
          bitCnt_ff <= bitCnt_ff + 4'h1;
        ST_RD_ACK:
          // A missing acknowledge ends the read; the line is already free.
          if (sdaS)
            state_ff <= ST_IDLE;
        default:
          state_ff <= state_ff;
      endcase
    end
    else if (sclFall)
    begin
      unique case (state_ff)
        ST_DEV:
          if (bitCnt_ff == 4'h8)
          begin
            // Answer only to the fixed prefix plus the three address pins.
            if (shiftIn_ff[7:1] == {`I2C_PREFIX, addrS})
            begin
              state_ff <= ST_DEV_ACK;
              rwBit_ff <= shiftIn_ff[0];
            end
            else
              state_ff <= ST_IDLE;
          end
        ST_DEV_ACK:
        begin
          bitCnt_ff <= 4'h0;
          if (rwBit_ff)
          begin
            // Reads skip the sub-address: the status byte is the only one.
            state_ff   <= ST_RD;
            rdShift_ff <= statusByte;
          end
          else
            state_ff <= ST_SUB;
        end
        ST_SUB:
          if (bitCnt_ff == 4'h8)
          begin
            state_ff  <= ST_SUB_ACK;
            subPtr_ff <= shiftIn_ff;
          end
        ST_SUB_ACK, ST_WR_ACK:
        begin
          state_ff  <= ST_WR;
          bitCnt_ff <= 4'h0;
        end
        ST_WR:
          if (bitCnt_ff == 4'h8)
          begin
            state_ff  <= ST_WR_ACK;
            subPtr_ff <= subPtr_ff + 8'h01;
          end
        ST_RD:
          if (bitCnt_ff == 4'h8)
            state_ff <= ST_RD_ACK;
          else
            rdShift_ff <= {rdShift_ff[6:0], 1'b1};
        ST_RD_ACK:
        begin
          // Master acknowledged: send the status byte once more.
          state_ff   <= ST_RD;
          bitCnt_ff  <= 4'h0;
          rdShift_ff <= statusByte;
        end
        default:
          state_ff <= state_ff;
      endcase
    end
  end

  // Data line driver: acknowledge slots and zero bits of the status byte.
  always_ff @(posedge clk)
  begin
    if (sys_rst || serialSelected)
      sdaOe <= 1'b0;
    else
      sdaOe <= (state_ff == ST_DEV_ACK) || (state_ff == ST_SUB_ACK) ||
               (state_ff == ST_WR_ACK) ||
               ((state_ff == ST_RD) && !rdShift_ff[7]);
  end

  // Configuration bytes. The done clear is written first so that a start
  // request landing in the same cycle overrides it and is not lost.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfgRegs_ff <= {`CFG_REG_COUNT{`CFG_BYTE_RST}};
    else
    begin
      if (calDone)
        cfgRegs_ff[5][`CAL_GO_BIT] <= 1'b0;
      // Sub-addresses beyond the last register are acknowledged but dropped.
      if (wrStrobe && (subPtr_ff <= `SUB_VCO_CAL))
        cfgRegs_ff[subPtr_ff[2:0]] <= shiftIn_ff;
      if (loadRise && serialSelected && !serAddr[1])
      begin
        unique case (serAddr)
          `SER_ADDR_WORD0: {cfgRegs_ff[3], cfgRegs_ff[4], cfgRegs_ff[5]} <= serWord;
          `SER_ADDR_WORD1: {cfgRegs_ff[0], cfgRegs_ff[1], cfgRegs_ff[2]} <= serWord;
        endcase
      end
    end
  end

  // Settings leave through flip-flops so the analog core sees clean levels.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg <= buildCfg({`CFG_REG_COUNT{`CFG_BYTE_RST}});
    else
      cfg <= buildCfg(cfgRegs_ff);
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_reset_clears_all: assert property (
    $past(sys_rst) && !sys_rst |-> (cfgRegs_ff == '0) ##1 (cfg.powerDown && !cfg.calGo))
    else $error("configuration not cleared by reset");

  chk_cal_done_clears: assert property (
    calDone && !(wrStrobe && subPtr_ff == `SUB_VCO_CAL) &&
    !(loadRise && serialSelected && serAddr == `SER_ADDR_WORD0)
    |=> !cfgRegs_ff[5][`CAL_GO_BIT] ##1 !cfg.calGo)
    else $error("calibration start bit not cleared on done");

  chk_cal_set_wins: assert property (
    calDone && wrStrobe && subPtr_ff == `SUB_VCO_CAL && shiftIn_ff[`CAL_GO_BIT]
    |=> cfgRegs_ff[5][`CAL_GO_BIT])
    else $error("calibration start lost against done");

  chk_serial_word_load: assert property (
    loadRise && serialSelected && serAddr == `SER_ADDR_WORD1
    |=> {cfgRegs_ff[0], cfgRegs_ff[1], cfgRegs_ff[2]} == $past(serWord) ##1
        cfg.bCount == $past(serWord[16:5], 2))
    else $error("serial word one not loaded");

  chk_reserved_ignored: assert property (
    loadRise && serialSelected && serAddr[1] && !wrStrobe && !calDone
    |=> $stable(cfgRegs_ff))
    else $error("reserved serial word changed registers");

  chk_serial_no_drive: assert property (
    serialSelected |=> !sdaOe && state_ff == ST_IDLE)
    else $error("two-wire port active while serial chosen");

  chk_write_increment: assert property (
    wrStrobe |=> subPtr_ff == $past(subPtr_ff) + 8'h01)
    else $error("sub-address did not advance");

  chk_read_status: assert property (
    state_ff == ST_DEV_ACK && sclFall && rwBit_ff
    |=> state_ff == ST_RD && rdShift_ff == $past(statusByte))
    else $error("read did not load status byte");

  chk_ack_driven: assert property (
    state_ff == ST_DEV_ACK && $past(state_ff) == ST_DEV_ACK |-> sdaOe)
    else $error("address acknowledge not driven");

  chk_mode_decode: assert property (
    cfg.opModeCode == 5'h00 || cfg.opModeCode > 5'h09 |-> cfg.powerDown &&
    cfg.vcoSrc == SRC_NONE)
    else $error("power down code not decoded");

  chk_ref_divider: assert property (
    ##1 cfg.refDiv == $past({cfgRegs_ff[3], cfgRegs_ff[4][7:6]}))
    else $error("reference divider misassembled");

  cov_i2c_write:   cover property (wrStrobe ##[1:200] wrStrobe);
  cov_i2c_read:    cover property (state_ff == ST_RD_ACK);
  cov_serial_load: cover property (loadRise && serialSelected);
  cov_cal_done:    cover property (cfg.calGo ##[1:500] calDone);

endmodule

// File: testbench/synth_host_model.sv
// Host-side model: a two-wire bus master and a three-wire serial writer.
// Assumes clk is the 50 MHz system clock and that the device pulls the
// data line low while sdaOe is high.
`timescale 1ns/1ps
module synth_host_model (
  // Timing reference.
  input  wire logic clk,
  // Two-wire bus.
  input  wire logic sdaOe,
  output logic      scl,
  output logic      sdaIn,
  // Three-wire bus.
  output logic      serClk,
  output logic      serData,
  output logic      serLoad
);
  logic sdaDrv;  // Master's open-drain drive; 1 releases the line.

  // The data line has a pull-up, so it is low whenever either party pulls.
  assign sdaIn = sdaDrv & ~sdaOe;

  // Idle levels: bus released, serial clock standing still.
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    serClk = 1'b0;
    serData = 1'b0;
    serLoad = 1'b0;
  end

  // Waits a number of system clock cycles, ending just after a falling edge.
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bus bit. Data moves only well after the clock falls, because the
  // device sees the clock through a synchroniser and would else see a start.
  task automatic bit_io(input logic b, output logic seen);
    sdaDrv = b;
    hold(6);
    scl = 1'b1;
    hold(5);
    seen = sdaIn;
    hold(5);
    scl = 1'b0;
    hold(6);
  endtask

  // Eight bits MSB first, then the acknowledge slot with the line released.
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ackLow);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    ackLow = !s;
  endtask

  // Start and stop conditions: data moves while the clock is high.
  task automatic start_cond();
    sdaDrv = 1'b1;
    hold(6);
    scl = 1'b1;
    hold(6);
    sdaDrv = 1'b0;
    hold(6);
    scl = 1'b0;
    hold(6);
  endtask

  task automatic stop_cond();
    sdaDrv = 1'b0;
    hold(6);
    scl = 1'b1;
    hold(6);
    sdaDrv = 1'b1;
    hold(6);
  endtask

  // Write: address, sub-address, data bytes; ok is high if all were acknowledged.
  task automatic i2c_write(input logic [6:0] dev, input logic [7:0] sub,
                           input logic [7:0] data [$], output logic ok);
    logic [7:0] rx;
    logic       ackLow;
    start_cond();
    xfer_byte({dev, 1'b0}, rx, ackLow);
    ok = ackLow;
    xfer_byte(sub, rx, ackLow);
    ok = ok & ackLow;
    foreach (data[i])
    begin
      xfer_byte(data[i], rx, ackLow);
      ok = ok & ackLow;
    end
    stop_cond();
  endtask

  // Read: no sub-address, one byte, left unacknowledged, then stop.
  task automatic i2c_read(input logic [6:0] dev, output logic [7:0] val, output logic ok);
    logic [7:0] rx;
    logic       ackLow;
    start_cond();
    xfer_byte({dev, 1'b1}, rx, ok);
    xfer_byte(8'hFF, val, ackLow);
    stop_cond();
  endtask

  // Serial frame: 26 bits MSB first at a 12 ns period, then a load pulse
  // with the clock held still around it. There is no readback path.
  task automatic ser_write(input logic [1:0] addr, input logic [23:0] word);
    logic [25:0] frame;
    frame = {addr, word};
    for (int i = 25; i >= 0; i--)
    begin
      serData = frame[i];
      #3;
      serClk = 1'b1;
      #6;
      serClk = 1'b0;
      #3;
    end
    // The released data line shows the inverse of the last bit, not a copy.
    serData = ~frame[0];
    #10;
    serLoad = 1'b1;
    #120;
    serLoad = 1'b0;
    #40;
  endtask
endmodule

// File: testbench/synth_config_register_bank_tb.sv
// Self-checking bench for the synthesizer configuration bank.
// Assumes the host model drives both buses and the bench drives pins.
`timescale 1ns/1ps
`include "synth_cfg_regs.svh"
module synth_config_register_bank_tb
  import synth_cfg_pkg::*;
;
  localparam logic [1:0] IDENT = 2'h3;  // Arbitrary identifier value.
  localparam logic [6:0] DEV = {`I2C_PREFIX, 3'h5};  // Our slave address.

  logic       clk;             // System clock.
  logic       sys_rst;         // Synchronous reset.
  logic       portSelStrap;    // Bus select strap.
  logic [2:0] addrPins;        // Slave address pins.
  logic       sdaOut;          // Open-drain data level, always low.
  synth_cfg_s cfgIdle;         // Settings expected after reset: power down.
  logic       scl;             // Two-wire clock.
  logic       sdaIn;           // Resolved data line.
  logic       sdaOe;           // Device pull-down enable.
  logic       serClk;          // Serial clock.
  logic       serData;         // Serial data.
  logic       serLoad;         // Load strobe.
  logic       pllLocked;       // Lock level from the core.
  logic [4:0] vcoWord;         // VCO control word from the core.
  logic       calDone;         // Calibration finished pulse.
  synth_cfg_s cfg;             // Decoded settings.
  logic       serialSelected;  // Selected port.
  int         errTotal = 0;    // Mismatches seen.
  int         nChecks = 0;     // Comparisons made.

  synth_config_register_bank #(.PART_IDENT(IDENT)) dut (
    .clk(clk), .sys_rst(sys_rst), .portSelectStrap(portSelStrap), .addrPins(addrPins),
    .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .serClk(serClk),
    .serData(serData), .serLoad(serLoad), .pllLockedPin(pllLocked),
    .vcoCtrlWordPin(vcoWord), .calDone(calDone), .cfg(cfg), .serialSelected(serialSelected));

  synth_host_model host (
    .clk(clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn),
    .serClk(serClk), .serData(serData), .serLoad(serLoad));

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (errTotal == 0 && nChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One comparison; case inequality so an unknown never matches.
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    nChecks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask

  // Full six-byte write from sub-address zero; fields of the first five bytes land in place.
  task automatic t_i2c_all();
    logic ok;
    host.i2c_write(DEV, 8'h00, '{8'h8B, 8'hA5, 8'hB3, 8'h3C, 8'h9D, 8'h00}, ok);
    chk("ack", 1, ok);
    chk("pinCtrl", 1, cfg.outStagePinCtrlOn);
    chk("recal", 0, cfg.recalAutoOn);
    chk("src", SRC_VCO_B, cfg.vcoSrc);
    chk("div", DIV_4, cfg.outDiv);
    chk("bCount", 12'hD2D, cfg.bCount);
    chk("aCount", 5'h13, cfg.aCount);
    chk("refDiv", 10'h0F2, cfg.refDiv);
    chk("amp", 2'h1, cfg.vcoAmplitude);
    chk("pump", 3'h6, cfg.pumpCurrentSel);
    chk("modulus", 1, cfg.modulusChoice);
  endtask

  // Walks every mode code and one beyond the table by single-byte writes.
  task automatic t_modes();
    logic     ok;
    vco_src_e eSrc;
    out_div_e eDiv;
    for (int c = 0; c <= 10; c++)
    begin
      host.i2c_write(DEV, 8'h00, '{8'(c << 1)}, ok);
      eSrc = (c >= 1 && c <= 9) ? vco_src_e'((c - 1) % 3 + 1) : SRC_NONE;
      eDiv = (c < 1 || c > 9) ? DIV_NONE : (c <= 3) ? DIV_2 : (c <= 6) ? DIV_4 : DIV_1;
      chk("mode", c, cfg.opModeCode);
      chk("powerDown", (c == 0 || c > 9), cfg.powerDown);
      chk("modeSrc", eSrc, cfg.vcoSrc);
      chk("modeDiv", eDiv, cfg.outDiv);
    end
  endtask

  // Calibration: full write with zero calibration byte, start, done, then
  // enable auto-restart keeping the other mode bits.
  task automatic t_cal();
    logic ok;
    host.i2c_write(DEV, 8'h00, '{8'h14, 8'hA5, 8'hB3, 8'h3C, 8'h9D, 8'h00}, ok);
    host.i2c_write(DEV, 8'h05, '{8'h40}, ok);
    chk("calGo set", 1, cfg.calGo);
    chk("cal test", 0, {cfg.testCtlA, cfg.testCtlB, cfg.calTrim});
    calDone = 1'b1;
    host.hold(1);
    calDone = 1'b0;
    host.hold(3);
    chk("calGo clear", 0, cfg.calGo);
    host.i2c_write(DEV, 8'h00, '{8'h54}, ok);
    chk("recal on", 1, cfg.recalAutoOn);
    chk("mode kept", 5'h0A, cfg.opModeCode);
  endtask

  // Status reads for locked and unlocked cores, no sub-address phase.
  task automatic t_status();
    logic [7:0] val;
    logic       ok;
    for (int k = 0; k < 2; k++)
    begin
      pllLocked = (k == 0);
      vcoWord = (k == 0) ? 5'h15 : 5'h0A;
      host.hold(6);
      host.i2c_read(DEV, val, ok);
      chk("read ack", 1, ok);
      chk("status", {IDENT, pllLocked, vcoWord}, val);
    end
  endtask

  // Wrong slave address and an unmapped sub-address change nothing.
  task automatic t_refuse();
    logic ok;
    host.i2c_write({4'hD, 3'h5}, 8'h00, '{8'hFF}, ok);
    chk("wrong addr ack", 0, ok);
    host.i2c_write(DEV, 8'h06, '{8'hFF}, ok);
    chk("sub6 ack", 1, ok);
    chk("mode after", 5'h0A, cfg.opModeCode);
    chk("ref after", 10'h0F2, cfg.refDiv);
    // Moving the address pins must retire the old address and enable the new one.
    addrPins = 3'h2;
    host.hold(6);
    host.i2c_write(DEV, 8'h00, '{8'hFF}, ok);
    chk("old addr ack", 0, ok);
    host.i2c_write({`I2C_PREFIX, 3'h2}, 8'h03, '{8'h3D}, ok);
    chk("new addr ack", 1, ok);
    chk("new addr ref", 10'h0F6, cfg.refDiv);
  endtask

  // Three-wire words 01 and 00, both reserved words 10 and 11, and the silenced two-wire port.
  task automatic t_serial();
    logic ok;
    portSelStrap = 1'b1;
    host.hold(6);
    chk("serialSel", 1, serialSelected);
    host.ser_write(2'h1, 24'h4E3C5A);
    chk("ser recal", 1, cfg.recalAutoOn);
    chk("ser mode", 5'h07, cfg.opModeCode);
    chk("ser src", SRC_VCO_A, cfg.vcoSrc);
    chk("ser bCount", 12'h1E2, cfg.bCount);
    chk("ser aCount", 5'h1A, cfg.aCount);
    host.ser_write(2'h0, 24'h816240);
    chk("ser refDiv", 10'h205, cfg.refDiv);
    chk("ser amp", 2'h2, cfg.vcoAmplitude);
    chk("ser pump", 3'h1, cfg.pumpCurrentSel);
    chk("ser calGo", 1, cfg.calGo);
    host.ser_write(2'h2, 24'hFFFFFF);
    host.ser_write(2'h3, 24'hFFFFFF);
    host.i2c_write(DEV, 8'h00, '{8'hFF}, ok);
    chk("strap ack", 0, ok);
    chk("rsvd mode", 5'h07, cfg.opModeCode);
    chk("rsvd ref", 10'h205, cfg.refDiv);
  endtask

  // Cuts a hang short: about 30,000 cycles, twice the expected run length.
  initial
  begin
    #600000;
    errTotal++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    sys_rst = 1'b1;
    portSelStrap = 1'b0;
    addrPins = 3'h5;
    cfgIdle = '0;
    cfgIdle.powerDown = 1'b1;
    pllLocked = 1'b0;
    vcoWord = 5'h00;
    calDone = 1'b0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    host.hold(6);
    chk("cfg reset", cfgIdle, cfg);
    chk("sdaOe reset", 0, sdaOe);
    chk("sdaOut", 0, sdaOut);
    t_i2c_all();
    t_modes();
    t_cal();
    t_status();
    t_refuse();
    t_serial();
    complete_run();
  end
endmodule
